// ---- src/mpi_ctrl.sv ----
// Purpose: Mask-driven interrupt recognition, trap entry and exit sequencing.
// Assumes: The core supplies the return address and memory read answers.
// Notes: Requests are asynchronous pins and pass a two-flop synchroniser.
`default_nettype none
// Notes on behaviour
// - Priority comes from software masks, then from line number.
// - Sixteen lines give sixteen priority levels.
// - Mask writes take effect from the next clock cycle.
// - Equal pending requests: lowest line wins.
// - Line zero outranks all others.
// - Mask bit n enables line n.
// - Trap stores return address, disables, jumps.
// - Taking an interrupt disables recognition.
// - Exit reads return, re-enables, resumes.
module mpi_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request pins
  input  wire logic [15:0] irq_req,
  // Core controls
  input  wire logic        mask_wr,
  input  wire logic [15:0] mask_wdata,
  input  wire logic        int_enable,
  input  wire logic        int_inhibit,
  input  wire logic        mode_65k,
  input  wire logic        overflow_in,
  input  wire logic [15:0] ret_addr,
  // Exit request
  input  wire logic        exit_req,
  input  wire logic [7:0]  exit_delta,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  // Trap entry outputs
  output logic             take_pulse,
  output logic [3:0]       take_state,
  output logic [15:0]      save_addr,
  output logic [15:0]      save_data,
  output logic [15:0]      jump_addr,
  output logic             ovf_clear,
  // Exit outputs
  output logic             rd_req,
  output logic [15:0]      rd_addr,
  output logic             resume_pulse,
  output logic [15:0]      resume_addr,
  output logic             ovf_load,
  output logic             ovf_value,
  // Status
  output logic             int_enabled,
  output logic [15:0]      mask_value
);
  logic [15:0]         irq_meta_reg;
  logic [15:0]         irq_sync_reg;
  logic [15:0]         mask_reg;
  logic                int_en_reg;
  mpi_pkg::mpi_state_t st_reg;
  mpi_pkg::mpi_state_t st_next;
  logic                take_reg;
  logic [3:0]          state_reg;
  logic [15:0]         save_addr_reg;
  logic [15:0]         save_data_reg;
  logic [15:0]         jump_addr_reg;
  logic                ovf_clr_reg;
  logic                rd_req_reg;
  logic [15:0]         rd_addr_reg;
  logic                resume_reg;
  logic [15:0]         resume_addr_reg;
  logic                ovf_load_reg;
  logic                ovf_val_reg;
  logic [15:0]         pending_w;
  logic                take_w;
  logic                exit_go_w;
  logic                exit_done_w;
  logic [15:0]         slot_w;
  logic [15:0]         save_w;
  logic [15:0]         exit_addr_w;
  logic                int_en_next;
  logic [15:0]         lower_w;

  mpi_pick_if pick ();

  mpi_pick mpi_pick_inst (
    .pk (pick.picker)
  );

  // A request is considered only when its own mask bit is set.
  assign pending_w = irq_sync_reg & mask_reg;
  assign pick.req  = pending_w;
  assign take_w    = (st_reg == mpi_pkg::ST_RUN) && int_en_reg && pick.any;
  assign exit_go_w = (st_reg == mpi_pkg::ST_RUN) && exit_req && !take_w;
  assign exit_done_w = (st_reg == mpi_pkg::ST_EXIT_WAIT) && rd_valid;
  assign slot_w = mpi_pkg::TRAP_BASE + 16'({pick.idx, 2'b00});
  // In 32K mode the top bit of the saved word carries the overflow state.
  assign save_w = mode_65k ? ret_addr
                           : {overflow_in, ret_addr[mpi_pkg::OVF_BIT-1:0]};
  assign exit_addr_w = mpi_pkg::TRAP_BASE + 16'(exit_delta);
  assign lower_w = ~(16'hFFFF << state_reg);

  // Trap entry clears the enable in the same edge; exit completion sets it.
  assign int_en_next = take_w      ? 1'b0 :
                       exit_done_w ? 1'b1 :
                       int_inhibit ? 1'b0 :
                       int_enable  ? 1'b1 : int_en_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      mpi_pkg::ST_RUN: begin
        if (exit_go_w) begin
          st_next = mpi_pkg::ST_EXIT_WAIT;
        end
      end
      mpi_pkg::ST_EXIT_WAIT: begin
        if (rd_valid) begin
          st_next = mpi_pkg::ST_RUN;
        end
      end
      default: begin
        st_next = mpi_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_meta_reg <= mpi_pkg::MASK_RST;
      irq_sync_reg <= mpi_pkg::MASK_RST;
    end else begin
      irq_meta_reg <= irq_req;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // Software may rewrite the mask at any time, even inside a handler.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_reg <= mpi_pkg::MASK_RST;
    end else if (mask_wr) begin
      mask_reg <= mask_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_en_reg <= 1'b0;
      st_reg     <= mpi_pkg::ST_RUN;
    end else begin
      int_en_reg <= int_en_next;
      st_reg     <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      take_reg      <= 1'b0;
      state_reg     <= mpi_pkg::IDX_RST;
      save_addr_reg <= mpi_pkg::ADDR_RST;
      save_data_reg <= mpi_pkg::ADDR_RST;
      jump_addr_reg <= mpi_pkg::ADDR_RST;
      ovf_clr_reg   <= 1'b0;
    end else begin
      take_reg    <= take_w;
      ovf_clr_reg <= take_w && !mode_65k;
      if (take_w) begin
        state_reg     <= pick.idx;
        save_addr_reg <= slot_w;
        save_data_reg <= save_w;
        jump_addr_reg <= slot_w + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_req_reg      <= 1'b0;
      rd_addr_reg     <= mpi_pkg::ADDR_RST;
      resume_reg      <= 1'b0;
      resume_addr_reg <= mpi_pkg::ADDR_RST;
      ovf_load_reg    <= 1'b0;
      ovf_val_reg     <= 1'b0;
    end else begin
      rd_req_reg   <= exit_go_w;
      resume_reg   <= exit_done_w;
      ovf_load_reg <= exit_done_w && !mode_65k;
      if (exit_go_w) begin
        rd_addr_reg <= exit_addr_w;
      end
      if (exit_done_w) begin
        // A 65K return address uses all sixteen bits, so overflow is left alone.
        resume_addr_reg <= mode_65k ? rd_data
                                    : {1'b0, rd_data[mpi_pkg::OVF_BIT-1:0]};
        ovf_val_reg     <= rd_data[mpi_pkg::OVF_BIT];
      end
    end
  end

  assign take_pulse   = take_reg;
  assign take_state   = state_reg;
  assign save_addr    = save_addr_reg;
  assign save_data    = save_data_reg;
  assign jump_addr    = jump_addr_reg;
  assign ovf_clear    = ovf_clr_reg;
  assign rd_req       = rd_req_reg;
  assign rd_addr      = rd_addr_reg;
  assign resume_pulse = resume_reg;
  assign resume_addr  = resume_addr_reg;
  assign ovf_load     = ovf_load_reg;
  assign ovf_value    = ovf_val_reg;
  assign int_enabled  = int_en_reg;
  assign mask_value   = mask_reg;

  a_take_masked: assert property (@(posedge clk) disable iff (!rst_n)
    take_reg |-> ((($past(pending_w) >> state_reg) & 16'h0001) == 16'h0001))
    else $error("Taken line was not enabled by the mask.");

  a_take_lowest: assert property (@(posedge clk) disable iff (!rst_n)
    take_reg |-> (($past(pending_w) & lower_w) == 16'h0000))
    else $error("A lower pending line was passed over.");

  a_line0_first: assert property (@(posedge clk) disable iff (!rst_n)
    (take_w && pending_w[0]) |=> (take_reg && state_reg == 4'h0))
    else $error("Line zero did not win.");

  a_take_disables: assert property (@(posedge clk) disable iff (!rst_n)
    take_reg |-> !int_en_reg ##1 (!take_reg))
    else $error("Recognition stayed on after a trap.");

  a_save_slot: assert property (@(posedge clk) disable iff (!rst_n)
    take_reg |-> (save_addr_reg == (mpi_pkg::TRAP_BASE + 16'({state_reg, 2'b00}))
                  && jump_addr_reg == save_addr_reg + 16'h0001))
    else $error("Return address slot is wrong.");

  a_mask_update: assert property (@(posedge clk) disable iff (!rst_n)
    mask_wr |=> (pending_w == (irq_sync_reg & $past(mask_wdata))))
    else $error("New mask not used for recognition.");

  a_off_no_take: assert property (@(posedge clk) disable iff (!rst_n)
    (!int_en_reg || pending_w == 16'h0000) |=> !take_reg)
    else $error("Trap taken without enabled request.");

  a_exit_read: assert property (@(posedge clk) disable iff (!rst_n)
    exit_go_w |=> (rd_req_reg && rd_addr_reg == mpi_pkg::TRAP_BASE + 16'($past(exit_delta))))
    else $error("Exit read address is wrong.");

  a_exit_resume: assert property (@(posedge clk) disable iff (!rst_n)
    (exit_done_w && mode_65k) |=> (resume_reg && int_en_reg
                                   && resume_addr_reg == $past(rd_data)))
    else $error("Exit did not resume with recognition on.");
endmodule // mpi_ctrl
`default_nettype wire

// ---- src/mpi_pick.sv ----
// Purpose: Picks the lowest-numbered pending request.
// Assumes: Requests are already masked.
// Notes: A ripple chain keeps the tie-break explicit and cheap.
`default_nettype none
module mpi_pick (
  // Request and winner
  mpi_pick_if.picker pk
);
  logic [15:0] below;
  logic [15:0] hit;

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_chain
      if (i == 0) begin : g_first
        assign below[i] = 1'b0;
      end else begin : g_rest
        assign below[i] = below[i-1] | pk.req[i-1];
      end
      assign hit[i] = pk.req[i] & ~below[i];
    end
  endgenerate

  always_comb begin
    pk.idx = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (hit[k]) begin
        pk.idx = pk.idx | 4'(k);
      end
    end
  end

  assign pk.any = |pk.req;
endmodule // mpi_pick
`default_nettype wire

// ---- src/mpi_pick_if.sv ----
// Purpose: Carries pending requests to the picker and the winner back.
// Assumes: One request bit per line.
// Notes: Purely combinational signals.
`default_nettype none
interface mpi_pick_if;
  logic [15:0] req;
  logic        any;
  logic [3:0]  idx;
  modport picker (input req, output any, output idx);
  modport user   (output req, input any, input idx);
endinterface
`default_nettype wire

// ---- src/mpi_pkg.sv ----
// Purpose: Shared constants for the masked priority interrupt logic.
// Assumes: Sixteen request lines and sixteen-bit addresses.
// Notes: Trap slots are four words apart starting at the trap base.
`default_nettype none
package mpi_pkg;
  localparam int          NUM_LINES  = 16;
  localparam int          IDX_W      = 4;
  localparam int          ADDR_W     = 16;
  localparam int          DELTA_W    = 8;
  localparam int          OVF_BIT    = 15;
  localparam int          SLOT_SHIFT = 2;
  localparam logic [15:0] TRAP_BASE  = 16'h0100;
  localparam logic [15:0] MASK_RST   = 16'h0000;
  localparam logic [15:0] ADDR_RST   = 16'h0000;
  localparam logic [3:0]  IDX_RST    = 4'h0;
  localparam logic [7:0]  DELTA_RST  = 8'h00;
  typedef enum logic [1:0] {ST_RUN, ST_EXIT_WAIT} mpi_state_t;
endpackage
`default_nettype wire

// ---- verification/masked_priority_interrupt_logic_test.sv ----
// Purpose: Self-checking bench for mask priority, trap entry and exit.
// Assumes: The memory partner answers every exit read.
// Notes: Each trap scenario is followed by its exit.
`default_nettype none
module masked_priority_interrupt_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, mask_wr, int_enable, mode_65k, overflow_in, exit_req, rd_valid, slow;
  logic [15:0] irq_req, mask_wdata, ret_addr, rd_data, save_addr, save_data, jump_addr;
  logic [15:0] rd_addr, resume_addr, mask_value;
  logic        int_inhibit;
  logic [7:0]  exit_delta;
  logic [3:0]  take_state;
  logic        take_pulse, ovf_clear, rd_req, resume_pulse, ovf_load, ovf_value, int_enabled;
  int          bad_count, cmp_count;

  mpi_ctrl mpi_ctrl_inst (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata), .int_enable(int_enable), .int_inhibit(int_inhibit),
    .mode_65k(mode_65k),
    .overflow_in(overflow_in), .ret_addr(ret_addr), .exit_req(exit_req),
    .exit_delta(exit_delta), .rd_valid(rd_valid), .rd_data(rd_data), .take_pulse(take_pulse),
    .take_state(take_state), .save_addr(save_addr), .save_data(save_data),
    .jump_addr(jump_addr), .ovf_clear(ovf_clear), .rd_req(rd_req), .rd_addr(rd_addr),
    .resume_pulse(resume_pulse), .resume_addr(resume_addr), .ovf_load(ovf_load),
    .ovf_value(ovf_value), .int_enabled(int_enabled), .mask_value(mask_value));
  mpi_mem_model mpi_mem_model_inst (.clk(clk), .rst_n(rst_n), .take_pulse(take_pulse),
    .save_addr(save_addr), .save_data(save_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .slow(slow), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Loads a mask, enables, raises requests, then checks the trap and the exit that follows.
  task automatic trap_and_exit(input logic [15:0] m, input logic [15:0] req, input logic m65,
                               input logic ovf, input logic [3:0] st);
    logic [15:0] ra;
    logic [15:0] slot;
    int          n;
    int          extra;
    logic [15:0] hmask;
    ra   = 16'hC3A0 ^ {12'h000, st};
    slot = 16'h0100 + {10'h000, st, 2'h0};
    hmask = m & ~(16'hFFFF << st);
    @(posedge clk);
    mask_wr     <= 1'b1;
    mask_wdata  <= m;
    mode_65k    <= m65;
    overflow_in <= ovf;
    ret_addr    <= ra;
    slow        <= st[0];
    @(posedge clk);
    mask_wr    <= 1'b0;
    int_enable <= 1'b1;
    @(posedge clk);
    int_enable <= 1'b0;
    irq_req    <= req;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (take_pulse !== 1'b1 && n < 12);
    if (take_pulse !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    check("mask_value", mask_value, m);
    check("take_state", {12'h000, take_state}, {12'h000, st});
    check("save_addr", save_addr, slot);
    check("jump_addr", jump_addr, slot + 16'h0001);
    check("save_data", save_data, m65 ? ra : {ovf, ra[14:0]});
    check("ovf_clear", {15'h0000, ovf_clear}, {15'h0000, ~m65});
    check("int_enabled", {15'h0000, int_enabled}, 16'h0000);
    // Requests stay up, yet no second trap may follow while recognition is off.
    extra = 0;
    repeat (5) begin
      @(posedge clk);
      #1;
      if (take_pulse === 1'b1) extra++;
    end
    check("extra_takes", 16'(extra), 16'h0000);
    // The handler keeps only more urgent lines, so the standing requests stay out.
    @(posedge clk);
    mask_wr    <= 1'b1;
    mask_wdata <= hmask;
    @(posedge clk);
    mask_wr    <= 1'b0;
    int_enable <= 1'b1;
    @(posedge clk);
    int_enable <= 1'b0;
    #1;
    check("int_enabled", {15'h0000, int_enabled}, 16'h0001);
    check("mask_value", mask_value, hmask);
    // Inhibit and enable together: inhibit must win.
    @(posedge clk);
    int_inhibit <= 1'b1;
    int_enable  <= 1'b1;
    irq_req     <= 16'h0000;
    #1;
    check("take_pulse", {15'h0000, take_pulse}, 16'h0000);
    @(posedge clk);
    int_inhibit <= 1'b0;
    int_enable  <= 1'b0;
    mask_wr     <= 1'b1;
    mask_wdata  <= m;
    #1;
    check("int_enabled", {15'h0000, int_enabled}, 16'h0000);
    @(posedge clk);
    mask_wr    <= 1'b0;
    exit_req   <= 1'b1;
    exit_delta <= {2'h0, st, 2'h0};
    @(posedge clk);
    exit_req <= 1'b0;
    #1;
    check("rd_req", {15'h0000, rd_req}, 16'h0001);
    check("rd_addr", rd_addr, slot);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (resume_pulse !== 1'b1 && n < 12);
    if (resume_pulse !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    check("resume_pulse", {15'h0000, resume_pulse}, 16'h0001);
    check("resume_addr", resume_addr, m65 ? ra : {1'b0, ra[14:0]});
    check("int_enabled", {15'h0000, int_enabled}, 16'h0001);
    check("ovf_load", {15'h0000, ovf_load}, {15'h0000, ~m65});
    check("ovf_value", {15'h0000, ovf_value}, {15'h0000, m65 ? ra[15] : ovf});
    @(posedge clk);
    int_enable <= 1'b0;
  endtask

  initial begin
    rst_n = 1'b0; mask_wr = 1'b0; int_enable = 1'b0; mode_65k = 1'b0; overflow_in = 1'b0;
    exit_req = 1'b0; slow = 1'b0; irq_req = 16'h0000; mask_wdata = 16'h0000;
    ret_addr = 16'h0000; exit_delta = 8'h00; bad_count = 0; cmp_count = 0;
    int_inhibit = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check("int_enabled", {15'h0000, int_enabled}, 16'h0000);
    check("mask_value", mask_value, 16'h0000);
    trap_and_exit(16'hFFFE, 16'h0029, 1'b1, 1'b1, 4'h3);
    trap_and_exit(16'h0020, 16'h003F, 1'b0, 1'b1, 4'h5);
    trap_and_exit(16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 4'h0);
    trap_and_exit(16'h8000, 16'h8000, 1'b1, 1'b0, 4'hF);
    trap_and_exit(16'h0400, 16'hFC00, 1'b0, 1'b1, 4'hA);
    report_and_stop();
  end
endmodule // masked_priority_interrupt_logic_test
`default_nettype wire

// ---- verification/mpi_mem_model.sv ----
// Purpose: Memory side partner that keeps trap return words and answers exit reads.
// Assumes: Slots lie in the low trap range, so six address bits select one.
// Notes: The answer is delayed by zero or three extra cycles, chosen by slow.
`default_nettype none
module mpi_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Trap store
  input  wire logic        take_pulse,
  input  wire logic [15:0] save_addr,
  input  wire logic [15:0] save_data,
  // Exit read
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  input  wire logic        slow,
  output logic             rd_valid,
  output logic [15:0]      rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] slot_mem [0:63];
  logic [1:0]  wait_cnt;
  logic        busy;
  // Outside an answer the data bus flips every cycle, so stale words never look valid.
  always_ff @(posedge clk) begin
    rd_valid <= 1'b0;
    rd_data  <= ~rd_data;
    if (!rst_n) begin
      busy    <= 1'b0;
      rd_data <= 16'h5A5A;
    end else begin
      if (take_pulse) begin
        slot_mem[save_addr[5:0]] <= save_data;
      end
      if (rd_req) begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy     <= 1'b0;
        rd_valid <= 1'b1;
        rd_data  <= slot_mem[rd_addr[5:0]];
      end
    end
  end
endmodule // mpi_mem_model
`default_nettype wire
